// ### verilog/crc_pkg.sv
// Shared constants and types for the memory-mapped CRC calculator.
// Contract
// - Select code 000 performs no CRC step on written data and keeps the result.
// - Codes 001, 010 and 011 choose x^8+x^2+x+1, x^16+x^15+x^2+1 and x^16+x^12+x^5+1.
// - Codes 100 and 101 choose the two 32-bit polynomials 0x04c11db7 and 0x1edc6f41.
// - Codes 110 and 111 are no-operation codes and compute nothing.
// - Bit 6 of the control register picks LSB-first or MSB-first bit ordering.
// - 8-bit and 16-bit modes take data in bytes, 32-bit modes in whole words.
// - A 32-bit mode folds a whole word in one step, 8-bit and 16-bit modes one byte per step.
// - The result reads as a word, halfword or byte matching the selected CRC size.
// - In module-stop the registers other than the stop bit keep their contents and no calculation happens.
package crc_pkg;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DIN_OFS = 8'h04;
    localparam logic [7:0] DOUT_OFS = 8'h08;
    localparam logic [7:0] STOP_OFS = 8'h0c;

    // Control and stop register field positions and mask of implemented control bits.
    localparam int POLY_SEL_LSB = 0;
    localparam int BIT_ORDER_POS = 6;
    localparam int STOP_POS = 0;
    localparam logic [7:0] CTRL_MASK = 8'h47;

    // Values after reset.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [31:0] DIN_RESET = 32'h0000_0000;
    localparam logic [31:0] DOUT_RESET = 32'h0000_0000;
    localparam logic STOP_RESET = 1'b0;

    // Polynomial select codes.
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_CRC8 = 3'h1;
    localparam logic [2:0] SEL_CRC16A = 3'h2;
    localparam logic [2:0] SEL_CRC16B = 3'h3;
    localparam logic [2:0] SEL_CRC32A = 3'h4;
    localparam logic [2:0] SEL_CRC32B = 3'h5;

    // Generator polynomials, top term implied.
    localparam logic [31:0] POLY_CRC8 = 32'h0000_0007;
    localparam logic [31:0] POLY_CRC16A = 32'h0000_8005;
    localparam logic [31:0] POLY_CRC16B = 32'h0000_1021;
    localparam logic [31:0] POLY_CRC32A = 32'h04c1_1db7;
    localparam logic [31:0] POLY_CRC32B = 32'h1edc_6f41;

    // AHB-Lite encodings.
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic bit_order_select;
        logic [2:0] poly_select;
    } ctrl_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] size;
        logic [7:0] addr;
    } ahb_phase_type;

endpackage

// ### verilog/crc_calculator.sv
// AHB-Lite CRC calculator with selectable 8, 16 and 32-bit generator polynomials.
`timescale 1ns/10ps

module crc_calculator (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // AHB-Lite slave request
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    // AHB-Lite slave response
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out
);

    // Width in bits of the CRC chosen by a select code, zero for no-operation codes.
    function automatic int crc_width(input logic [2:0] sel);
        int w;
        w = 0;
        case (sel)
            crc_pkg::SEL_CRC8: w = 8;
            crc_pkg::SEL_CRC16A, crc_pkg::SEL_CRC16B: w = 16;
            crc_pkg::SEL_CRC32A, crc_pkg::SEL_CRC32B: w = 32;
            default: w = 0;
        endcase
        return w;
    endfunction

    function automatic logic [31:0] crc_poly(input logic [2:0] sel);
        logic [31:0] p;
        p = 32'h0000_0000;
        case (sel)
            crc_pkg::SEL_CRC8: p = crc_pkg::POLY_CRC8;
            crc_pkg::SEL_CRC16A: p = crc_pkg::POLY_CRC16A;
            crc_pkg::SEL_CRC16B: p = crc_pkg::POLY_CRC16B;
            crc_pkg::SEL_CRC32A: p = crc_pkg::POLY_CRC32A;
            crc_pkg::SEL_CRC32B: p = crc_pkg::POLY_CRC32B;
            default: p = 32'h0000_0000;
        endcase
        return p;
    endfunction

    function automatic logic [31:0] width_mask(input int w);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 32; i++) begin
            if (i < w) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Folds n data bits into the CRC. MSB-first shifts left against the plain
    // polynomial; LSB-first shifts right against the bit-reversed polynomial.
    function automatic logic [31:0] crc_fold(input logic [31:0] crc,
                                             input logic [31:0] data,
                                             input logic [2:0] sel,
                                             input logic msb_first,
                                             input int n);
        logic [31:0] c;
        logic [31:0] p;
        logic [31:0] rp;
        logic d;
        logic fb;
        int w;
        w = crc_width(sel);
        p = crc_poly(sel);
        rp = 32'h0000_0000;
        c = crc & width_mask(w);
        d = 1'b0;
        fb = 1'b0;
        for (int j = 0; j < 32; j++) begin
            if (j < w) begin
                rp[j] = p[w - 1 - j];
            end
        end
        for (int i = 0; i < 32; i++) begin
            if (i < n && w > 0) begin
                if (msb_first) begin
                    d = data[n - 1 - i];
                    fb = c[w - 1] ^ d;
                    c = {c[30:0], 1'b0};
                    if (fb) begin
                        c = c ^ p;
                    end
                end else begin
                    d = data[i];
                    fb = c[0] ^ d;
                    c = {1'b0, c[31:1]};
                    if (fb) begin
                        c = c ^ rp;
                    end
                end
            end
        end
        return c & width_mask(w);
    endfunction

    // Byte lanes touched by a transfer of the given size at the given address.
    function automatic logic [3:0] lane_enable(input logic [2:0] size, input logic [1:0] a);
        logic [3:0] be;
        case (size)
            crc_pkg::HSIZE_BYTE: be = 4'h1 << a;
            crc_pkg::HSIZE_HALF: be = a[1] ? 4'hc : 4'h3;
            default: be = 4'hf;
        endcase
        return be;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (be[k]) begin
                r[8 * k +: 8] = wdata[8 * k +: 8];
            end
        end
        return r;
    endfunction

    crc_pkg::ahb_phase_type phase;
    crc_pkg::ahb_phase_type next_phase;
    crc_pkg::ctrl_type ctrl;
    crc_pkg::ctrl_type next_ctrl;
    logic [31:0] data_in;
    logic [31:0] next_data_in;
    logic [31:0] data_out;
    logic [31:0] next_data_out;
    logic module_stop;
    logic next_module_stop;
    logic [31:0] next_hrdata;

    // Write-side decode of the data phase.
    logic wr_active;
    logic [3:0] wr_be;
    logic [7:0] wr_byte;
    logic [7:0] ctrl_image;
    logic [7:0] ctrl_written;
    logic [31:0] ctrl_merged;
    logic [7:0] wr_word;
    logic [7:0] rd_word;
    logic crc_step;
    logic [31:0] step_data;
    int step_bits;
    int out_width;

    always_comb begin
        next_phase.valid = hsel_in & htrans_in[1] & hready_in;
        next_phase.write = hwrite_in;
        next_phase.size = hsize_in;
        // The low address bits are kept to steer byte lanes; decode uses the word address.
        next_phase.addr = haddr_in[7:0];
    end

    always_comb begin
        wr_active = phase.valid & phase.write;
        wr_word = {phase.addr[7:2], 2'b00};
        wr_be = lane_enable(phase.size, phase.addr[1:0]);
        wr_byte = hwdata_in[8 * phase.addr[1:0] +: 8];
        ctrl_image = 8'h00;
        ctrl_image[crc_pkg::POLY_SEL_LSB +: 3] = ctrl.poly_select;
        ctrl_image[crc_pkg::BIT_ORDER_POS] = ctrl.bit_order_select;
        ctrl_merged = merge({24'h00_0000, ctrl_image}, hwdata_in, wr_be);
        ctrl_written = ctrl_merged[7:0] & crc_pkg::CTRL_MASK;

        next_module_stop = module_stop;
        next_ctrl = ctrl;
        next_data_in = data_in;
        next_data_out = data_out;
        crc_step = 1'b0;
        step_data = 32'h0000_0000;
        step_bits = 0;

        if (wr_active && wr_word == crc_pkg::STOP_OFS && wr_be[0]) begin
            next_module_stop = hwdata_in[crc_pkg::STOP_POS];
        end

        // While stopped every register except the stop bit holds still and nothing is computed.
        if (wr_active && !module_stop) begin
            case (wr_word)
                crc_pkg::CTRL_OFS: begin
                    next_ctrl.poly_select = ctrl_written[crc_pkg::POLY_SEL_LSB +: 3];
                    next_ctrl.bit_order_select = ctrl_written[crc_pkg::BIT_ORDER_POS];
                end
                crc_pkg::DIN_OFS: begin
                    next_data_in = merge(data_in, hwdata_in, wr_be);
                    case (crc_width(ctrl.poly_select))
                        32: begin
                            // A partial write cannot form a whole word, so it is not folded.
                            crc_step = phase.size == crc_pkg::HSIZE_WORD;
                            step_data = hwdata_in;
                            step_bits = 32;
                        end
                        8, 16: begin
                            crc_step = 1'b1;
                            step_data = {24'h00_0000, wr_byte};
                            step_bits = 8;
                        end
                        default: begin
                            crc_step = 1'b0;
                        end
                    endcase
                end
                crc_pkg::DOUT_OFS: begin
                    next_data_out = merge(data_out, hwdata_in, wr_be);
                end
                default: begin
                end
            endcase
        end

        if (crc_step) begin
            next_data_out = crc_fold(data_out, step_data, ctrl.poly_select,
                                     ctrl.bit_order_select, step_bits);
        end
    end

    // Read data is taken from the next-state values so a read that follows a write
    // back to back sees the written or folded value without a wait state.
    always_comb begin
        next_hrdata = 32'h0000_0000;
        out_width = crc_width(next_ctrl.poly_select);
        rd_word = {next_phase.addr[7:2], 2'b00};
        if (next_phase.valid && !next_phase.write) begin
            case (rd_word)
                crc_pkg::CTRL_OFS: begin
                    next_hrdata[crc_pkg::POLY_SEL_LSB +: 3] = next_ctrl.poly_select;
                    next_hrdata[crc_pkg::BIT_ORDER_POS] = next_ctrl.bit_order_select;
                end
                crc_pkg::DIN_OFS: next_hrdata = next_data_in;
                crc_pkg::DOUT_OFS: begin
                    if (out_width == 0) begin
                        next_hrdata = next_data_out;
                    end else begin
                        next_hrdata = next_data_out & width_mask(out_width);
                    end
                end
                crc_pkg::STOP_OFS: next_hrdata[crc_pkg::STOP_POS] = next_module_stop;
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            phase <= '0;
            ctrl <= crc_pkg::ctrl_type'({crc_pkg::CTRL_RESET[6], crc_pkg::CTRL_RESET[2:0]});
            data_in <= crc_pkg::DIN_RESET;
            data_out <= crc_pkg::DOUT_RESET;
            module_stop <= crc_pkg::STOP_RESET;
            hrdata_out <= 32'h0000_0000;
        end else begin
            phase <= next_phase;
            ctrl <= next_ctrl;
            data_in <= next_data_in;
            data_out <= next_data_out;
            module_stop <= next_module_stop;
            hrdata_out <= next_hrdata;
        end
    end

    // Every access completes with zero wait states and an OKAY response.
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

endmodule

// ### testbench/crc_calculator_chk.sv
// Checker for bus replies and result register of the CRC calculator.
`timescale 1ns/10ps
module crc_calculator_chk (
    // Clock, reset and bus request
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    // Bus response
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out
);
    logic dv, dw, stop, rd_d, wr_a, wr_di, noop;
    logic [7:0] da;
    logic [3:0] ctl;
    assign rd_d = dv & ~dw & (da == crc_pkg::DOUT_OFS);
    assign wr_a = dv & dw & (da != crc_pkg::STOP_OFS);
    assign wr_di = wr_a & (da == crc_pkg::DIN_OFS);
    assign noop = (ctl[2:0] == 3'h0) | (ctl[2:1] == 2'h3);
    // Shadows of data phase, control and stop are rebuilt from bus traffic.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            dv <= 1'b0;
            dw <= 1'b0;
            da <= 8'h00;
            ctl <= 4'h0;
            stop <= 1'b0;
        end else begin
            dv <= hsel_in & htrans_in[1] & hready_in;
            dw <= hwrite_in;
            da <= haddr_in[7:0];
            if (wr_a && da == crc_pkg::CTRL_OFS && !stop) begin
                ctl <= {hwdata_in[6], hwdata_in[2:0]};
            end
            if (dv && dw && da == crc_pkg::STOP_OFS) begin
                stop <= hwdata_in[0];
            end
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence noop_fold;
        rd_d ##2 (wr_di && noop) ##2 rd_d;
    endsequence
    sequence stopped_write;
        rd_d ##2 (wr_a && stop) ##2 rd_d;
    endsequence
    sequence seed_read;
        (wr_a && da == crc_pkg::DOUT_OFS && noop && !stop) ##2 rd_d;
    endsequence
    a_idle_zero: assert property (!(dv && !dw) |-> hrdata_out == 32'h0)
        else $error("read data outside a read");
    a_ctrl_read: assert property (dv && !dw && da == crc_pkg::CTRL_OFS
        |-> hrdata_out == {25'h0, ctl[3], 3'h0, ctl[2:0]}) else $error("control readback");
    a_crc8_width: assert property (rd_d && ctl[2:0] == 3'h1 |-> hrdata_out[31:8] == 24'h0)
        else $error("8-bit result too wide");
    a_crc16_width: assert property (rd_d && ctl[2:1] == 2'h1
        |-> hrdata_out[31:16] == 16'h0) else $error("16-bit result too wide");
    a_dout_steady: assert property (rd_d ##1 !wr_a ##1 rd_d
        |-> hrdata_out == $past(hrdata_out, 2)) else $error("result drifted");
    a_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("bus reply not ready and okay");
    a_noop_hold: assert property (noop_fold |-> hrdata_out == $past(hrdata_out, 4))
        else $error("no-op code changed result");
    a_stop_freeze: assert property (stopped_write |-> hrdata_out == $past(hrdata_out, 4))
        else $error("result changed while stopped");
    a_seed_load: assert property (seed_read |-> hrdata_out == $past(hwdata_in, 2))
        else $error("seed not loaded");
endmodule
bind crc_calculator crc_calculator_chk u_chk (.clk_in, .srst_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out);

// ### testbench/tb.sv
// Self-checking bench for the CRC calculator driven over AHB-Lite.
`timescale 1ns/10ps
module tb;
    typedef struct packed {
        logic [2:0] sel;
        logic msb;
        logic [7:0] addr;
        logic [31:0] data;
        logic [31:0] seed;
    } row_type;
    logic clk_in, srst_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out, bm;
    logic [1:0] htrans_in;
    logic [2:0] hsize_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rd, exp;
    int mismatches, compares;
    row_type r;
    row_type rows [8] = '{
        '{3'h1, 1'b1, 8'h05, 32'h0000_3100, 32'h0000_00ff},
        '{3'h2, 1'b0, 8'h07, 32'ha500_0000, 32'h0000_0000},
        '{3'h3, 1'b1, 8'h04, 32'h0000_005a, 32'h0000_ffff},
        '{3'h4, 1'b0, 8'h04, 32'h1234_5678, 32'hffff_ffff},
        '{3'h5, 1'b1, 8'h04, 32'hdead_beef, 32'h0000_0000},
        '{3'h0, 1'b0, 8'h04, 32'h1111_2222, 32'h1357_9bdf},
        '{3'h6, 1'b1, 8'h04, 32'h3333_4444, 32'h2468_ace0},
        '{3'h7, 1'b0, 8'h04, 32'h5555_6666, 32'h0f0f_f0f0}};
    assign hready_in = hreadyout_out;
    crc_calculator u_crc_calculator (.clk_in, .srst_in, .hsel_in, .haddr_in, .htrans_in,
        .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out);
    function automatic logic [31:0] crc_ref(logic [31:0] c, logic [31:0] d, logic [2:0] s,
                                            logic msb);
        logic [31:0] p, rp, m;
        int w, nb;
        if (s == 3'h0 || s > 3'h5) return c;
        w = s == 3'h1 ? 8 : s < 3'h4 ? 16 : 32;
        nb = w == 32 ? 32 : 8;
        p = s == 3'h1 ? crc_pkg::POLY_CRC8 : s == 3'h2 ? crc_pkg::POLY_CRC16A :
            s == 3'h3 ? crc_pkg::POLY_CRC16B : s == 3'h4 ? crc_pkg::POLY_CRC32A :
            crc_pkg::POLY_CRC32B;
        m = 32'hffff_ffff >> (32 - w);
        rp = 32'h0;
        for (int i = 0; i < w; i++) rp[w - 1 - i] = p[i];
        for (int i = 0; i < nb; i++) begin
            if (msb) c = ((c << 1) & m) ^ ((c[w - 1] ^ d[nb - 1 - i]) ? p : 32'h0);
            else c = (c >> 1) ^ ((c[0] ^ d[i]) ? rp : 32'h0);
        end
        return c;
    endfunction
    task automatic bus(logic w, logic [7:0] a, logic [2:0] sz, logic [31:0] wd);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        hwrite_in <= w;
        haddr_in <= {24'h0, a};
        hsize_in <= sz;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        rd = hrdata_out;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] wd);
        bus(1'b1, a, 3'h2, wd);
    endtask
    task automatic rdchk(logic [7:0] a, logic [31:0] want);
        bus(1'b0, a, 3'h2, 32'h0);
        compares++;
        if (rd !== want) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, rd, want);
        end
    endtask
    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        repeat (2000) @(posedge clk_in);
        mismatches++;
        end_sim();
    end
    initial begin
        srst_in = 1'b1;
        hsel_in = 1'b0;
        htrans_in = 2'h0;
        hwrite_in = 1'b0;
        hsize_in = 3'h0;
        haddr_in = 32'h0;
        hwdata_in = 32'h0;
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            bm = r.sel inside {[1:3]};
            wr(crc_pkg::CTRL_OFS, {25'h0, r.msb, 3'h0, r.sel});
            wr(crc_pkg::DOUT_OFS, r.seed);
            rdchk(crc_pkg::DOUT_OFS, r.seed);
            bus(1'b1, r.addr, bm ? 3'h0 : 3'h2, r.data);
            exp = bm ? r.data >> {r.addr[1:0], 3'h0} : r.data;
            exp = crc_ref(r.seed, exp, r.sel, r.msb);
            rdchk(crc_pkg::DOUT_OFS, exp);
            rdchk(crc_pkg::DOUT_OFS, exp);
            rdchk(crc_pkg::CTRL_OFS, {25'h0, r.msb, 3'h0, r.sel});
            $display("row %0d done", i);
        end
        // A byte write in 32-bit mode must fold nothing, then two words chain.
        wr(crc_pkg::CTRL_OFS, 32'h4);
        wr(crc_pkg::DOUT_OFS, 32'hffff_ffff);
        bus(1'b1, crc_pkg::DIN_OFS, 3'h0, 32'h55);
        rdchk(crc_pkg::DOUT_OFS, 32'hffff_ffff);
        wr(crc_pkg::DIN_OFS, 32'h0102_0304);
        wr(crc_pkg::DIN_OFS, 32'haabb_ccdd);
        exp = crc_ref(32'hffff_ffff, 32'h0102_0304, 3'h4, 1'b0);
        exp = crc_ref(exp, 32'haabb_ccdd, 3'h4, 1'b0);
        rdchk(crc_pkg::DOUT_OFS, exp);
        $display("word chain done");
        wr(crc_pkg::STOP_OFS, 32'h1);
        rdchk(crc_pkg::DOUT_OFS, exp);
        wr(crc_pkg::DIN_OFS, 32'h1234);
        rdchk(crc_pkg::DOUT_OFS, exp);
        wr(crc_pkg::CTRL_OFS, 32'h1);
        rdchk(crc_pkg::CTRL_OFS, 32'h4);
        wr(crc_pkg::STOP_OFS, 32'h0);
        wr(8'h10, 32'hffff_ffff);
        rdchk(8'h10, 32'h0);
        $display("stop and unmapped done");
        // A halfword write in 16-bit mode folds only the byte at its address.
        wr(crc_pkg::CTRL_OFS, 32'h3);
        wr(crc_pkg::DOUT_OFS, 32'h0);
        bus(1'b1, 8'h06, 3'h1, 32'h00ab_0000);
        rdchk(crc_pkg::DOUT_OFS, crc_ref(32'h0, 32'hab, 3'h3, 1'b0));
        rdchk(crc_pkg::DIN_OFS, 32'h00ab_ccdd);
        $display("halfword lane done");
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        rdchk(crc_pkg::CTRL_OFS, 32'h0);
        rdchk(crc_pkg::DIN_OFS, 32'h0);
        rdchk(crc_pkg::DOUT_OFS, 32'h0);
        $display("reset done");
        end_sim();
    end
endmodule
